// ===== wdr_pkg.sv
// package: register map, field layout and timing constants for the watchdog
package wdr_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_RESET_FLAG = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'hC;
  // control field layout
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 3;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;
  // key codes and reset values
  localparam logic [4:0] KEY_ENABLE     = 5'h0A;
  localparam logic [4:0] KEY_DISABLE    = 5'h15;
  localparam logic [7:0] CONTROL_RESET  = 8'h53;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  // interrupt status bit positions
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_KEYBAD  = 1;
  localparam int IRQ_WIDTH   = 2;
  // counter width and soft reset delay in slow clock ticks
  localparam int CNT_WIDTH          = 18;
  localparam int SOFT_RESET_TICKS   = 4;
  localparam int SOFT_RESET_WIDTH   = 3;
  // slow oscillator nominal rate and system clock rate
  localparam int SLOW_OSC_HZ = 32000;
  localparam int SYS_CLK_HZ  = 100000000;
endpackage : wdr_pkg

// ===== wdr_timer.sv
// watchdog reset timer with avalon-mm register slave
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - the count advances only on ticks of the slow internal oscillator.
// - the period select field picks an overflow at 2^8,10,12,14,15,16,17,18.
// - key 01010B enables the watchdog and key 10101B disables it.
// - any other key value forces a full reset after the soft reset delay.
// - an invalid key sets the register reset flag, cleared only by software or the reset input.
// - after reset the key is the enable code and the period select is 011.
// - an overflow in normal running resets the device and sets timeout flag.
// - an overflow in sleep or idle sets the flag and resets only pc and sp.
// - the count clears on invalid key, clear instruction, halt or reset pin.
// - only reset, the clear instruction, halt, invalid key, reset pin and overflow clear the count.
// - halt clears the count, which keeps running only when enabled.
module wdr_timer #(
  parameter int CNT_WIDTH = wdr_pkg::CNT_WIDTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // slow oscillator, asynchronous to clk
  input  wire logic        slow_internal_osc,
  // cpu events, one-cycle pulses on clk, and the low power mode level
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        halt_instruction,
  input  wire logic        low_power_mode,
  // external reset pin, active low, and its reset function select
  input  wire logic        reset_pin_n,
  input  wire logic        reset_pin_selected,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // reset requests and timeout flag toward the device
  output logic             device_reset,
  output logic             pc_sp_reset,
  output logic             watchdog_expired_flag,
  // interrupt
  output logic             irq
);

  // register state
  logic [7:0]             watchdog_control;
  logic                   watchdog_register_reset_flag;
  logic [wdr_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [wdr_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic                   ack;
  // synchronisers
  logic [1:0]             osc_sync;
  logic                   osc_prev;
  logic [1:0]             pin_sync;
  // counter and soft reset delay
  logic [CNT_WIDTH-1:0]   count;
  logic [wdr_pkg::SOFT_RESET_WIDTH-1:0] soft_delay;
  logic                   soft_pending;

  // field decode
  wire [4:0] watchdog_key_field =
    watchdog_control[wdr_pkg::KEY_MSB:wdr_pkg::KEY_LSB];
  wire [2:0] period_select_field =
    watchdog_control[wdr_pkg::SEL_MSB:wdr_pkg::SEL_LSB];
  wire key_enable  = watchdog_key_field == wdr_pkg::KEY_ENABLE;
  wire key_disable = watchdog_key_field == wdr_pkg::KEY_DISABLE;
  wire key_invalid = !key_enable && !key_disable;

  // rising edge of the synchronised slow clock; second stage only
  wire slow_tick = osc_sync[1] && !osc_prev;

  // terminal count bit per period select
  logic [4:0] term_bit;
  always_comb begin
    unique case (period_select_field)
      3'h0:    term_bit = 5'h08;
      3'h1:    term_bit = 5'h0A;
      3'h2:    term_bit = 5'h0C;
      3'h3:    term_bit = 5'h0E;
      3'h4:    term_bit = 5'h0F;
      3'h5:    term_bit = 5'h10;
      3'h6:    term_bit = 5'h11;
      3'h7:    term_bit = 5'h12;
    endcase
  end

  // overflow once the count reaches 2^n - 1 and another tick arrives
  wire [CNT_WIDTH:0] count_ext = {1'b0, count} + {{CNT_WIDTH{1'b0}}, 1'b1};
  wire overflow = key_enable && slow_tick && count_ext[term_bit];

  // pin reset only when the pin carries its reset function
  wire pin_reset = reset_pin_selected && !pin_sync[1];
  wire soft_fire = soft_pending &&
    soft_delay == wdr_pkg::SOFT_RESET_WIDTH'(wdr_pkg::SOFT_RESET_TICKS);
  // the sources that clear the count, besides reset and overflow
  wire count_clear = watchdog_clear_instruction || halt_instruction ||
                     soft_fire || pin_reset;

  // bus decode
  wire req       = (avs_read || avs_write) && !ack;
  wire sel_ctl   = avs_address == wdr_pkg::ADDR_CONTROL;
  wire sel_flag  = avs_address == wdr_pkg::ADDR_RESET_FLAG;
  wire sel_stat  = avs_address == wdr_pkg::ADDR_IRQ_STATUS;
  wire sel_mask  = avs_address == wdr_pkg::ADDR_IRQ_MASK;
  wire wr_lane0  = req && avs_write && avs_byteenable[0];
  wire wr_ctl    = wr_lane0 && sel_ctl;
  wire wr_flag   = wr_lane0 && sel_flag;
  wire wr_mask   = wr_lane0 && sel_mask;
  wire rd_stat   = req && avs_read && sel_stat;

  // one wait state: answer on the cycle after the request
  assign avs_waitrequest = !ack;

  // read data mux
  wire [31:0] rd_mux =
    sel_ctl  ? {24'h000000, watchdog_control} :
    sel_flag ? {31'h00000000, watchdog_register_reset_flag} :
    sel_stat ? {30'h00000000, irq_status} :
    sel_mask ? {30'h00000000, irq_mask} : wdr_pkg::READ_UNMAPPED;

  // synchronisers and edge memory
  always_ff @(posedge clk) begin
    osc_sync <= {osc_sync[0], slow_internal_osc};
    osc_prev <= osc_sync[1];
    pin_sync <= {pin_sync[0], reset_pin_n};
  end

  // bus handshake and read data
  always_ff @(posedge clk) begin
    if (reset) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack          <= req;
      avs_readdata <= req ? rd_mux : avs_readdata;
    end
  end

  // control register, restored by reset and by the invalid key reset
  always_ff @(posedge clk) begin
    if (reset || soft_fire) begin
      watchdog_control <= wdr_pkg::CONTROL_RESET;
    end else if (wr_ctl) begin
      watchdog_control <= avs_writedata[7:0];
    end
  end

  // register reset flag: set beats the software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_register_reset_flag <= 1'b0;
    end else if (soft_fire) begin
      watchdog_register_reset_flag <= 1'b1;
    end else if (wr_flag && !avs_writedata[0]) begin
      watchdog_register_reset_flag <= 1'b0;
    end
  end

  // soft reset delay counted in slow ticks, holds the reset off briefly
  always_ff @(posedge clk) begin
    if (reset || soft_fire || !key_invalid) begin
      soft_pending <= 1'b0;
      soft_delay   <= '0;
    end else begin
      soft_pending <= 1'b1;
      if (slow_tick && soft_pending) begin
        soft_delay <= soft_delay + 1'b1;
      end
    end
  end

  // watchdog count; frozen while disabled, cleared by the listed events
  always_ff @(posedge clk) begin
    if (reset || count_clear || overflow) begin
      count <= '0;
    end else if (key_enable && slow_tick) begin
      count <= count_ext[CNT_WIDTH-1:0];
    end
  end

  // reset outputs: full reset in run mode or on invalid key, pc/sp only on low power overflow
  always_ff @(posedge clk) begin
    if (reset) begin
      device_reset <= 1'b0;
      pc_sp_reset  <= 1'b0;
    end else begin
      device_reset <= (overflow && !low_power_mode) || soft_fire;
      pc_sp_reset  <= overflow && low_power_mode;
    end
  end

  // timeout flag, cleared by halt or the clear instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_expired_flag <= 1'b0;
    end else if (overflow) begin
      watchdog_expired_flag <= 1'b1;
    end else if (watchdog_clear_instruction || halt_instruction) begin
      watchdog_expired_flag <= 1'b0;
    end
  end

  // interrupt status: events win over the read clear
  wire [wdr_pkg::IRQ_WIDTH-1:0] irq_events = {soft_fire, overflow};
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= (rd_stat ? '0 : irq_status) | irq_events;
      if (wr_mask) begin
        irq_mask <= avs_writedata[wdr_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // checks: steps of multi-cycle behaviours as named sequences
  sequence s_bus_ready;
    !avs_waitrequest;
  endsequence
  sequence s_bus_idle;
    avs_waitrequest;
  endsequence
  sequence s_run_overflow;
    overflow && !low_power_mode;
  endsequence
  sequence s_sleep_overflow;
    overflow && low_power_mode;
  endsequence
  sequence s_key_bad_held;
    key_invalid ##1 key_invalid;
  endsequence

  // invalid key: flag, reset request, control restore and status
  a_key_reset_flag: assert property (
    @(posedge clk) disable iff (reset)
    soft_fire |=> watchdog_register_reset_flag && device_reset)
    else $error("key reset did not set flag and reset");
  a_flag_hold: assert property (
    @(posedge clk) disable iff (reset)
    watchdog_register_reset_flag && !wr_flag |=> watchdog_register_reset_flag)
    else $error("reset flag dropped without software");
  a_key_restore: assert property (
    @(posedge clk) disable iff (reset)
    soft_fire |=> watchdog_control == wdr_pkg::CONTROL_RESET)
    else $error("control not restored after key reset");
  a_key_status: assert property (
    @(posedge clk) disable iff (reset)
    soft_fire |=> irq_status[wdr_pkg::IRQ_KEYBAD])
    else $error("key reset status bit not set");
  a_key_pending: assert property (
    @(posedge clk) disable iff (reset)
    s_key_bad_held |-> soft_pending)
    else $error("invalid key did not arm the delay");
  a_key_settled: assert property (
    @(posedge clk) disable iff (reset)
    !key_invalid |=> !soft_pending)
    else $error("delay armed with a valid key");

  // overflow outcomes in run and low power modes
  a_run_reset: assert property (
    @(posedge clk) disable iff (reset)
    s_run_overflow |=> device_reset && !pc_sp_reset && watchdog_expired_flag)
    else $error("run overflow wrong");
  a_sleep_reset: assert property (
    @(posedge clk) disable iff (reset)
    s_sleep_overflow |=> pc_sp_reset && !device_reset && watchdog_expired_flag)
    else $error("sleep overflow wrong");
  a_status_timeout: assert property (
    @(posedge clk) disable iff (reset)
    overflow |=> irq_status[wdr_pkg::IRQ_TIMEOUT])
    else $error("timeout status bit not set");
  a_reset_pulse: assert property (
    @(posedge clk) disable iff (reset)
    device_reset |=> !device_reset)
    else $error("device reset longer than one cycle");
  a_sleep_pulse: assert property (
    @(posedge clk) disable iff (reset)
    pc_sp_reset |=> !pc_sp_reset)
    else $error("pc sp reset longer than one cycle");
  a_reset_apart: assert property (
    @(posedge clk) disable iff (reset)
    !(device_reset && pc_sp_reset))
    else $error("both reset kinds at once");

  // count clearing, stepping and freezing
  a_clear_count: assert property (
    @(posedge clk) disable iff (reset)
    watchdog_clear_instruction || halt_instruction |=> count == '0)
    else $error("count not cleared");
  a_pin_clear: assert property (
    @(posedge clk) disable iff (reset)
    pin_reset |=> count == '0)
    else $error("pin reset did not clear count");
  a_halt_flag: assert property (
    @(posedge clk) disable iff (reset)
    (halt_instruction || watchdog_clear_instruction) && !overflow
    |=> !watchdog_expired_flag)
    else $error("timeout flag survived halt or clear");
  a_disabled_hold: assert property (
    @(posedge clk) disable iff (reset)
    key_disable && !count_clear |=> $stable(count))
    else $error("count moved while disabled");
  a_count_step: assert property (
    @(posedge clk) disable iff (reset)
    !slow_tick && !count_clear |=> $stable(count))
    else $error("count moved without a slow tick");
  a_count_incr: assert property (
    @(posedge clk) disable iff (reset)
    key_enable && slow_tick && !count_clear && !overflow
    |=> count == $past(count) + 1'b1)
    else $error("count did not advance by one");
  a_no_overflow: assert property (
    @(posedge clk) disable iff (reset)
    !key_enable |-> !overflow)
    else $error("overflow while off");
  a_term_count: assert property (
    @(posedge clk) disable iff (reset)
    overflow && period_select_field == 3'h0 |-> count == 18'h000FF)
    else $error("wrong terminal count");

  // bus: one wait state, ready for one cycle, read data held between
  a_bus_answer: assert property (
    @(posedge clk) disable iff (reset)
    req |=> s_bus_ready ##1 s_bus_idle)
    else $error("bus answer timing wrong");
  a_rdata_hold: assert property (
    @(posedge clk) disable iff (reset)
    !req |=> $stable(avs_readdata))
    else $error("read data changed without a request");

endmodule : wdr_timer
`default_nettype wire

// ===== watchdog_reset_timer_bench.sv
// self-checking bench for the watchdog reset timer
`timescale 1ns/10ps
`default_nettype none
module watchdog_reset_timer_bench;
  logic        clk = 1'b0, reset = 1'b1, slow = 1'b0;
  logic        clr = 1'b0, halt = 1'b0, lpm = 1'b0;
  logic        pin_n = 1'b1, pin_sel = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [3:0]  adr = 4'h0, be = 4'h0;
  logic [31:0] wd = 32'h0, rdata, seed = 32'h3F, r;
  logic        wait_r, dev_rst, pcsp, flag, irq, ws;
  int          ticks = 0, dv = 0, n_errors = 0, checked = 0, t;
  logic [31:0] rq[$];
  int          tq[$];
  localparam int PCSP = 1 << 24;
  wdr_timer dut_u (.clk(clk), .reset(reset), .slow_internal_osc(slow),
    .watchdog_clear_instruction(clr), .halt_instruction(halt),
    .low_power_mode(lpm), .reset_pin_n(pin_n), .reset_pin_selected(pin_sel),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .device_reset(dev_rst), .pc_sp_reset(pcsp),
    .watchdog_expired_flag(flag), .irq(irq));
  always #5 clk = ~clk;
  // slow clock at an eighth of clk, so long periods stay short in time
  always @(posedge clk) begin
    dv <= (dv == 3) ? 0 : dv + 1;
    if (dv == 3) slow <= ~slow;
    if (dv == 3 && !slow) ticks <= ticks + 1;
  end
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task cmp_rd(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: read %h, expected %h", $time, g, e);
    end
  endtask : cmp_rd
  task cmp_tick(input int e, input int g);
    checked++;
    if (g < e - 1 || g > e + 1) begin
      n_errors++;
      $display("unexpected at %0t: reset code %0d, expected %0d", $time, g, e);
    end
  endtask : cmp_tick
  task cmp_bit(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: level %b, expected %b", $time, g, e);
    end
  endtask : cmp_bit
  // one bus cycle; released at the edge where waitrequest is seen low
  task bus(input logic [3:0] a, input logic w, input logic [7:0] b,
           input logic [3:0] en);
    r = xs();
    @(posedge clk);
    adr <= a; wr <= w; rd <= !w; wd <= {r[31:8], b}; be <= en;
    ws = 1'b1;
    while (ws) begin
      @(posedge clk);
      ws = wait_r;
    end
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  task rdx(input logic [3:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(a, 1'b0, 8'h00, 4'hF);
  endtask : rdx
  task pulse(input int which);
    @(posedge clk);
    if (which == 0) clr <= 1'b1; else halt <= 1'b1;
    @(posedge clk);
    clr <= 1'b0; halt <= 1'b0;
  endtask : pulse
  task wait_ticks(input int n);
    t = ticks;
    while (ticks < t + n) @(negedge clk);
  endtask : wait_ticks
  task wait_q();
    while (tq.size() != 0) @(negedge clk);
    @(negedge clk);
  endtask : wait_q
  task stop_test();
    $display("errors %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // watcher: read data and reset pulses against the oldest note
  always @(negedge clk) begin
    if (rd && !wait_r) cmp_rd(rq.pop_front(), rdata);
    if (dev_rst || pcsp)
      cmp_tick(tq.pop_front(), ticks + (pcsp ? PCSP : 0));
  end
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rdx(wdr_pkg::ADDR_CONTROL, 8'h53);
    rdx(wdr_pkg::ADDR_RESET_FLAG, 8'h00);
    rdx(4'h1, 8'h00);
    bus(4'h1, 1'b1, 8'hFF, 4'hF);
    bus(wdr_pkg::ADDR_IRQ_MASK, 1'b1, 8'h03, 4'hF);
    for (int s = 0; s < 3; s++) begin
      bus(wdr_pkg::ADDR_CONTROL, 1'b1, {wdr_pkg::KEY_ENABLE, 3'(s)}, 4'hF);
      pulse(0);
      tq.push_back(ticks + (1 << (8 + 2 * s)));
      wait_q();
      cmp_bit(1'b1, flag);
      cmp_bit(1'b1, irq);
      rdx(wdr_pkg::ADDR_IRQ_STATUS, 8'h01);
      cmp_bit(1'b0, irq);
      pulse(0);
      @(negedge clk);
      cmp_bit(1'b0, flag);
    end
    bus(wdr_pkg::ADDR_CONTROL, 1'b1, {wdr_pkg::KEY_ENABLE, 3'h0}, 4'hF);
    // keep-alive at random spacing; each clear pulse follows a mask register write
    for (int i = 0; i < 3; i++) begin
      r = xs();
      wait_ticks(100 + r[6:0]);
      bus(wdr_pkg::ADDR_IRQ_MASK, 1'b1, 8'h03, 4'hF);
      pulse(0);
    end
    wait_ticks(150);
    pulse(1);
    tq.push_back(ticks + 256);
    wait_q();
    @(posedge clk) lpm <= 1'b1;
    tq.push_back(ticks + 256 + PCSP);
    wait_q();
    @(posedge clk) lpm <= 1'b0;
    wait_ticks(100);
    @(posedge clk) pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
    tq.push_back(ticks + 256);
    wait_q();
    bus(wdr_pkg::ADDR_CONTROL, 1'b1, {wdr_pkg::KEY_DISABLE, 3'h0}, 4'hF);
    wait_ticks(300);
    bus(wdr_pkg::ADDR_CONTROL, 1'b1, {wdr_pkg::KEY_ENABLE, 3'h0}, 4'h0);
    wait_ticks(300);
    rdx(wdr_pkg::ADDR_IRQ_STATUS, 8'h01);
    // masked event: the invalid key sets status but leaves irq low
    bus(wdr_pkg::ADDR_IRQ_MASK, 1'b1, 8'h01, 4'hF);
    bus(wdr_pkg::ADDR_CONTROL, 1'b1, 8'h01, 4'hF);
    tq.push_back(ticks + wdr_pkg::SOFT_RESET_TICKS);
    wait_q();
    cmp_bit(1'b0, irq);
    rdx(wdr_pkg::ADDR_IRQ_STATUS, 8'h02);
    rdx(wdr_pkg::ADDR_CONTROL, 8'h53);
    rdx(wdr_pkg::ADDR_RESET_FLAG, 8'h01);
    bus(wdr_pkg::ADDR_RESET_FLAG, 1'b1, 8'h01, 4'hF);
    rdx(wdr_pkg::ADDR_RESET_FLAG, 8'h01);
    bus(wdr_pkg::ADDR_RESET_FLAG, 1'b1, 8'h00, 4'hF);
    rdx(wdr_pkg::ADDR_RESET_FLAG, 8'h00);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule : watchdog_reset_timer_bench
`default_nettype wire
